/* core/fagcr_pkg.sv */
// constants for the fast address gate and cpu reset block
package fagcr_pkg;
    localparam logic [15:0] FAGCR_REG_ADDR     = 16'h0092;
    localparam logic [7:0]  FAGCR_REG_RESET    = 8'h24;
    localparam logic [7:0]  FAGCR_FIXED_MASK   = 8'hFC;
    localparam logic [7:0]  FAGCR_FIXED_VALUE  = 8'h24;
    localparam int          FAGCR_BIT_RST      = 0;
    localparam int          FAGCR_BIT_GATE     = 1;
    localparam int          FAGCR_CLK_HZ       = 20000000;
    localparam int          FAGCR_DELAY_NS     = 14000;
    localparam int          FAGCR_PULSE_NS     = 6000;
    localparam int          FAGCR_CLK_NS       = 1000000000 / FAGCR_CLK_HZ;
    // least times round up to whole cycles
    localparam int          FAGCR_DELAY_CYC    = (FAGCR_DELAY_NS + FAGCR_CLK_NS - 1) / FAGCR_CLK_NS;
    localparam int          FAGCR_PULSE_CYC    = (FAGCR_PULSE_NS + FAGCR_CLK_NS - 1) / FAGCR_CLK_NS;
    localparam int          FAGCR_CNT_W        = 10;

    typedef enum logic [1:0]
    {
        FAGCR_IDLE  = 2'b00,
        FAGCR_WAIT  = 2'b01,
        FAGCR_PULSE = 2'b10,
        FAGCR_DONE  = 2'b11
    } fagcr_state_t;
endpackage

/* core/fagcr_top.sv */
// fast address gate and fast cpu reset register with pulse timer
`timescale 1ns/1ps
// Summary of operation
// (RULE1) gate and reset come from keyboard controller or from the fast register.
// (RULE2) fast register access only while configuration enable bit is set.
// (RULE3) reserved bits read back as fixed 00,1,0,0,1 pattern.
// (RULE4) bit 1 written sets the fast address gate level.
// (RULE5) reset clears bit 0; bit 0 is host readable and writable.
// (RULE6) writing bit 0 high gives low pulse of 6 us after 14 us delay.
// (RULE7) bit 0 must return to 0 before another pulse is made.
// (RULE8) after reset the fast cpu reset output stays high, bit 0 zero.
// (RULE9) after reset the fast address gate is low.
// (RULE10) when enabled, fast pulse ANDs with controller reset onto reset pin.
// (RULE11) address mask low only when controller gate bit and fast gate both 0.
// (RULE12) controller port bit acts as the software address gate input.
// (RULE13) write of 1 to bit 0 detected; counters on device clock time it.
// (RULE14) while disabled, writes ignored and reads leave data bus undriven.
module fagcr_top
    import fagcr_pkg::*;
#(
    parameter int DELAY_CYC = fagcr_pkg::FAGCR_DELAY_CYC,
    parameter int PULSE_CYC = fagcr_pkg::FAGCR_PULSE_CYC
)
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rdata_oe,
    input  wire logic        kbc_reset_gate_config,
    input  wire logic        kbc_gate_port_bit,
    input  wire logic        kbc_cpu_reset_n,
    input  wire logic        reset_pin_invert,
    output logic             fast_addr_gate,
    output logic             fast_cpu_reset_n,
    output logic             cpu_addr_wrap_mask_n,
    output logic             keyboard_reset_out
);
    import fagcr_pkg::*;

    logic [1:0]             en_sync_ff;
    logic [1:0]             gate_sync_ff;
    logic [1:0]             kbrst_sync_ff;
    logic [1:0]             inv_sync_ff;
    logic                   rst_bit_ff;
    logic                   gate_bit_ff;
    logic [7:0]             rdata_ff;
    logic                   rdata_oe_ff;
    fagcr_state_t           state_ff;
    fagcr_state_t           nxt_state;
    logic [FAGCR_CNT_W-1:0] cnt_ff;
    logic [FAGCR_CNT_W-1:0] nxt_cnt;
    logic                   pulse_ff;
    logic                   out_mask_ff;
    logic                   out_kbrst_ff;
    logic                   hit;
    logic                   wr_hit;
    logic                   rd_hit;
    logic                   arm;
    logic                   cfg_en;
    logic                   kbc_gate_s;
    logic                   kbc_rst_n_s;
    logic                   pin_invert_s;
    logic                   fast_rst_n_ff;

    // pins from other devices are asynchronous to clk
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_sync_ff    <= 2'h0;
            gate_sync_ff  <= 2'h0;
            kbrst_sync_ff <= 2'h3;
            inv_sync_ff   <= 2'h0;
        end
        else
        begin
            en_sync_ff    <= {en_sync_ff[0], kbc_reset_gate_config};
            gate_sync_ff  <= {gate_sync_ff[0], kbc_gate_port_bit};
            kbrst_sync_ff <= {kbrst_sync_ff[0], kbc_cpu_reset_n};
            inv_sync_ff   <= {inv_sync_ff[0], reset_pin_invert};
        end
    end

    // only the second stage of each synchroniser is read
    assign cfg_en       = en_sync_ff[1];
    assign kbc_gate_s   = gate_sync_ff[1];
    assign kbc_rst_n_s  = kbrst_sync_ff[1];
    assign pin_invert_s = inv_sync_ff[1];

    assign hit    = (io_addr == FAGCR_REG_ADDR) && cfg_en; // RULE2
    assign wr_hit = hit && io_wr; // RULE14
    assign rd_hit = hit && io_rd; // RULE14
    // only a 0-to-1 change of bit 0 starts a pulse
    assign arm    = wr_hit && io_wdata[FAGCR_BIT_RST] && !rst_bit_ff; // RULE7 RULE13

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_bit_ff <= FAGCR_REG_RESET[FAGCR_BIT_RST]; // RULE5 RULE8
        end
        else if (wr_hit)
        begin
            rst_bit_ff <= io_wdata[FAGCR_BIT_RST]; // RULE5
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gate_bit_ff <= FAGCR_REG_RESET[FAGCR_BIT_GATE]; // RULE9
        end
        else if (wr_hit)
        begin
            gate_bit_ff <= io_wdata[FAGCR_BIT_GATE]; // RULE4
        end
    end

    // bus left undriven when not addressed
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_oe_ff <= 1'b0;
        end
        else
        begin
            rdata_oe_ff <= rd_hit; // RULE14
        end
    end

    // byte holds between reads; harmless while oe is low
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_ff <= 8'h00;
        end
        else if (rd_hit)
        begin
            rdata_ff <= (FAGCR_FIXED_VALUE & FAGCR_FIXED_MASK)
                      | {6'h00, gate_bit_ff, rst_bit_ff}; // RULE3
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            FAGCR_IDLE:
            begin
                if (arm)
                begin
                    nxt_state = FAGCR_WAIT; // RULE13
                end
            end
            FAGCR_WAIT:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_state = FAGCR_PULSE; // RULE6
                end
            end
            FAGCR_PULSE:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_state = FAGCR_DONE; // RULE6
                end
            end
            FAGCR_DONE:
            begin
                // rearm only after bit 0 is back at 0
                if (!rst_bit_ff)
                begin
                    nxt_state = FAGCR_IDLE; // RULE7
                end
            end
        endcase
    end

    // one down counter serves both phases, loaded on entry to each
    always_comb
    begin
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            FAGCR_IDLE:
            begin
                if (arm)
                begin
                    nxt_cnt = FAGCR_CNT_W'(DELAY_CYC - 1); // RULE6
                end
            end
            FAGCR_WAIT:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_cnt = FAGCR_CNT_W'(PULSE_CYC - 1); // RULE6
                end
                else
                begin
                    nxt_cnt = cnt_ff - 1'b1; // RULE13
                end
            end
            FAGCR_PULSE:
            begin
                if (cnt_ff != '0)
                begin
                    nxt_cnt = cnt_ff - 1'b1; // RULE13
                end
            end
            FAGCR_DONE:
            begin
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= FAGCR_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_ff <= '0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

    // a write of 0 mid pulse does not cut it short
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pulse_ff <= 1'b0;
        end
        else
        begin
            pulse_ff <= (nxt_state == FAGCR_PULSE); // RULE6
        end
    end

    // own flop so the cpu reset pin has no inverter after the register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fast_rst_n_ff <= 1'b1; // RULE8
        end
        else
        begin
            fast_rst_n_ff <= (nxt_state != FAGCR_PULSE); // RULE6
        end
    end

    // outputs from flops so the cpu pins never glitch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_mask_ff <= 1'b0;
        end
        else
        begin
            out_mask_ff <= kbc_gate_s | gate_bit_ff; // RULE11 RULE12
        end
    end

    // fast pulse only counts while the register is enabled
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_kbrst_ff <= 1'b0;
        end
        else
        begin
            out_kbrst_ff <= (kbc_rst_n_s & (!cfg_en | !pulse_ff))
                          ^ pin_invert_s; // RULE1 RULE10
        end
    end

    assign fast_addr_gate       = gate_bit_ff; // RULE4
    assign fast_cpu_reset_n     = fast_rst_n_ff; // RULE8
    assign cpu_addr_wrap_mask_n = out_mask_ff;
    assign keyboard_reset_out   = out_kbrst_ff;
    assign io_rdata             = rdata_ff;
    assign io_rdata_oe          = rdata_oe_ff;
endmodule

/* dv/fagcr_kbc_model.sv */
// keyboard controller side model driving gate and reset levels
`timescale 1ns/1ps
module fagcr_kbc_model
(
    input  wire logic clk,
    input  wire logic rst_req,
    input  wire logic gate_req,
    output logic      kbc_cpu_reset_n = 1'b1,
    output logic      kbc_gate_port_bit = 1'b0
);
    // moves on the falling edge, clear of the block's sampling edge
    always @(negedge clk)
    begin
        kbc_cpu_reset_n   <= rst_req;
        kbc_gate_port_bit <= gate_req;
    end
endmodule

/* dv/fagcr_top_asserts.sv */
// port assertions for the fast gate and reset block
`timescale 1ns/1ps
module fagcr_asserts
    import fagcr_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [15:0] io_addr,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rdata_oe,
    input wire logic        kbc_reset_gate_config,
    input wire logic        kbc_gate_port_bit,
    input wire logic        fast_addr_gate,
    input wire logic        cpu_addr_wrap_mask_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    rd_fixed_a: assert property (io_rdata_oe |-> (io_rdata & FAGCR_FIXED_MASK) == FAGCR_FIXED_VALUE)
        else $error("reserved bits read wrong");
    rd_addr_a: assert property (io_rd && io_addr != FAGCR_REG_ADDR |=> !io_rdata_oe)
        else $error("read of other address answered");
    // enable passes two sync stages, so four low samples make it certain
    rd_off_a: assert property ((!kbc_reset_gate_config)[*4] ##0 io_rd |=> !io_rdata_oe)
        else $error("read answered while disabled");
    wr_off_a: assert property ((!kbc_reset_gate_config)[*4] ##0 io_wr |=> $stable(fast_addr_gate))
        else $error("write taken while disabled");
    gate_wr_a: assert property ($changed(fast_addr_gate) |-> $past(io_wr)
        && $past(io_addr) == FAGCR_REG_ADDR && fast_addr_gate == $past(io_wdata[1]))
        else $error("gate moved without a write");
    rd_gate_a: assert property (io_rdata_oe |-> io_rdata[1] == $past(fast_addr_gate))
        else $error("gate bit read wrong");
    mask_hi_a: assert property (fast_addr_gate[*2] |-> cpu_addr_wrap_mask_n)
        else $error("mask low with gate high");
    mask_lo_a: assert property ((!fast_addr_gate && !kbc_gate_port_bit)[*4] |-> !cpu_addr_wrap_mask_n)
        else $error("mask high with both gates low");
endmodule
bind fagcr_top fagcr_asserts u_chk (.clk, .arst_n, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata, .io_rdata_oe, .kbc_reset_gate_config, .kbc_gate_port_bit, .fast_addr_gate,
    .cpu_addr_wrap_mask_n);

/* dv/fagcr_top_tb.sv */
// self-checking bench for the fast gate and reset block
`timescale 1ns/1ps
module fagcr_top_tb;
    import fagcr_pkg::*;
    localparam int DLY = 3;
    localparam int PLS = 2;
    logic        clk = 0, arst_n = 0, io_wr = 0, io_rd = 0, kbc_reset_gate_config = 0;
    logic        reset_pin_invert = 0, k_rst = 1, k_gate = 0, kbc_cpu_reset_n, kbc_gate_port_bit;
    logic        io_rdata_oe, fast_addr_gate, fast_cpu_reset_n, cpu_addr_wrap_mask_n;
    logic        keyboard_reset_out, o;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0]  io_wdata = 8'h00, io_rdata, d;
    int          errors = 0, num_checks = 0, n, m, kl;
    fagcr_top #(.DELAY_CYC(DLY), .PULSE_CYC(PLS)) u_dut (.clk, .arst_n, .io_addr, .io_wr,
        .io_rd, .io_wdata, .io_rdata, .io_rdata_oe, .kbc_reset_gate_config, .kbc_gate_port_bit,
        .kbc_cpu_reset_n, .reset_pin_invert, .fast_addr_gate, .fast_cpu_reset_n,
        .cpu_addr_wrap_mask_n, .keyboard_reset_out);
    fagcr_kbc_model u_kbc (.clk, .rst_req(k_rst), .gate_req(k_gate), .kbc_cpu_reset_n,
        .kbc_gate_port_bit);
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        io_addr = a;
        io_wdata = v;
        io_wr = 1;
        @(negedge clk);
        io_wr = 0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(negedge clk);
        io_addr = a;
        io_rd = 1;
        @(negedge clk);
        d = io_rdata;
        o = io_rdata_oe;
        io_rd = 0;
    endtask
    // delay and width in cycles; kl counts low samples of the reset pin
    task automatic pulse();
        n = 0;
        m = 0;
        kl = 0;
        while (fast_cpu_reset_n === 1'b1 && n < 30)
        begin
            @(negedge clk);
            n++;
        end
        while (fast_cpu_reset_n === 1'b0 && m < 30)
        begin
            @(negedge clk);
            m++;
            kl += (keyboard_reset_out === 1'b0);
        end
    endtask
    task automatic t_reset();
        check(fast_cpu_reset_n, 1'b1);
        check(fast_addr_gate, 1'b0);
        kbc_reset_gate_config = 1;
        repeat (4) @(negedge clk);
        rd(FAGCR_REG_ADDR);
        check(o, 1'b1);
        check(d, FAGCR_REG_RESET);
        $display("test reset done");
    endtask
    task automatic t_gate();
        for (int i = 0; i < 4; i++)
        begin
            k_gate = i[1];
            wr(FAGCR_REG_ADDR, 8'hF8 | {6'h00, i[0], 1'b0});
            repeat (4) @(negedge clk);
            check(fast_addr_gate, i[0]);
            check(cpu_addr_wrap_mask_n, i[0] | i[1]);
            rd(FAGCR_REG_ADDR);
            check(d, 8'h24 | {6'h00, i[0], 1'b0});
        end
        $display("test gate done");
    endtask
    task automatic t_pulse();
        wr(FAGCR_REG_ADDR, 8'h01);
        pulse();
        check(n, DLY);
        check(m, PLS);
        check(kl > 0, 1'b1);
        wr(FAGCR_REG_ADDR, 8'h01);
        pulse();
        check(m, 8'h00);
        wr(FAGCR_REG_ADDR, 8'h00);
        wr(FAGCR_REG_ADDR, 8'h01);
        pulse();
        check(m, PLS);
        k_rst = 0;
        repeat (6) @(negedge clk);
        check(keyboard_reset_out, 1'b0);
        reset_pin_invert = 1;
        repeat (6) @(negedge clk);
        check(keyboard_reset_out, 1'b1);
        k_rst = 1;
        reset_pin_invert = 0;
        $display("test pulse done");
    endtask
    task automatic t_off();
        kbc_reset_gate_config = 0;
        repeat (4) @(negedge clk);
        wr(FAGCR_REG_ADDR, 8'h02);
        repeat (2) @(negedge clk);
        check(fast_addr_gate, 1'b0);
        rd(FAGCR_REG_ADDR);
        check(o, 1'b0);
        kbc_reset_gate_config = 1;
        repeat (4) @(negedge clk);
        rd(16'h0093);
        check(o, 1'b0);
        $display("test off done");
    endtask
    // reset in mid-run with both bits set and no pulse pending must restore reset values
    task automatic t_rerst();
        wr(FAGCR_REG_ADDR, 8'h03);
        repeat (2) @(negedge clk);
        arst_n = 0;
        repeat (2) @(negedge clk);
        arst_n = 1;
        check(fast_cpu_reset_n, 1'b1);
        check(fast_addr_gate, 1'b0);
        repeat (4) @(negedge clk);
        rd(FAGCR_REG_ADDR);
        check(d, FAGCR_REG_RESET);
        pulse();
        check(m, 8'h00);
        $display("test mid reset done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        arst_n = 1;
        t_reset();
        t_gate();
        t_pulse();
        t_off();
        t_rerst();
        give_verdict();
    end
    initial
    begin
        #200000;
        errors++;
        give_verdict();
    end
endmodule
